// >>> verilog/gfm_consts.svh
`ifndef GFM_CONSTS_SVH
`define GFM_CONSTS_SVH
`define GFM_NPINS        5
`define GFM_FUNC_W       4
`define GFM_F_DISABLED   4'h0
`define GFM_F_OUTPUT     4'h1
`define GFM_F_INPUT      4'h2
`define GFM_F_NETSTAT    4'h3
`define GFM_F_POS_SUPPLY 4'h4
`define GFM_F_TX_BURST   4'h5
`define GFM_F_DATA_RDY   4'h6
`define GFM_F_AID_SYNC   4'h7
`define GFM_F_SIM_DET    4'h8
`define GFM_PIN1_RST     4'h0
`define GFM_PIN2_RST     4'h4
`define GFM_PIN3_RST     4'h6
`define GFM_PIN4_RST     4'h7
`define GFM_PIN5_RST     4'h8
`define GFM_NS_HOME      2'h0
`define GFM_NS_ROAM      2'h1
`define GFM_NS_DATA      2'h2
`define GFM_NS_NOSVC     2'h3
`define GFM_NS_SLOW_HALF 24'h5F5E10
`define GFM_NS_FAST_HALF 24'h17D784
`define GFM_NS_BLINK_ON  24'h02FAF0
`endif

// >>> verilog/gfm_pkg.sv
`include "gfm_consts.svh"
package gfm_pkg;
  typedef logic [`GFM_FUNC_W-1:0] gfm_func_t;
  typedef struct packed {
    logic [`GFM_NPINS-1:0] out;
    logic [`GFM_NPINS-1:0] oe;
    logic [`GFM_NPINS-1:0] pd;
  } gfm_pad_s;
  typedef struct packed {
    logic      valid;
    logic [2:0] pin;
    gfm_func_t func;
  } gfm_cfg_s;
  typedef struct packed {
    logic [23:0] cnt;
    logic        lvl;
  } gfm_ns_state_s;
endpackage : gfm_pkg

// >>> verilog/gfm_netstat.sv
`timescale 1ns/1ps
module gfm_netstat
  import gfm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // network state
  input  wire logic [1:0] net_state,
  // indicator level
  output logic            ns_level
);
  gfm_ns_state_s st_r;
  gfm_ns_state_s st_nxt;

  // home: slow blink, roaming: fast blink, data: steady on, no service: short flash
  always_comb begin
    logic [23:0] lim;
    lim = `GFM_NS_SLOW_HALF;
    st_nxt = st_r;
    case (net_state)
      `GFM_NS_HOME:  lim = `GFM_NS_SLOW_HALF;
      `GFM_NS_ROAM:  lim = `GFM_NS_FAST_HALF;
      `GFM_NS_DATA:  lim = `GFM_NS_SLOW_HALF;
      default:       lim = st_r.lvl ? `GFM_NS_BLINK_ON : `GFM_NS_SLOW_HALF;
    endcase
    if (st_r.cnt >= lim - 24'h000001) begin
      st_nxt.cnt = 24'h000000;
      st_nxt.lvl = ~st_r.lvl;
    end else begin
      st_nxt.cnt = st_r.cnt + 24'h000001;
    end
    if (net_state == `GFM_NS_DATA) begin
      st_nxt.lvl = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ns_level = st_r.lvl;
endmodule : gfm_netstat

// >>> verilog/gfm_mux.sv
`timescale 1ns/1ps
// Functional notes
// - five pins, each an input, an output or a special function not held by another pin.
// - pin one in burst mode is high while a transmit burst is in progress.
// - positioning supply pin is driven high while mode is 1, else tri-state with pull-down.
// - positioning supply defaults to pin two and may move to pins one, three, four or five.
// - data ready pin is sensed for wake-up while mode is 1, else tri-state with pull-down.
// - aiding sync pin outputs the timing signal while mode is 1, else tri-state with pull-down.
// - any pin may show one of four network states.
// - an input pin's level is readable by the host.
// - an output pin drives the written level and its pad level is readable.
// - a disabled pin is tri-stated with pull-down and does nothing.
// - pin one resets disabled; allowed: output, input, network, supply, burst.
// - pin two resets to supply; allowed: output, input, network, disabled.
// - pin three resets to data ready; allowed: output, input, network, supply, disabled.
// - pin four resets to aiding sync; allowed: output, input, network, supply, disabled.
// - pin five resets to SIM detect; allowed: output, input, network, supply, disabled.
module gfm_mux
  import gfm_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // pin function config command
  input  wire logic                  cfg_wr,
  input  wire logic [2:0]            cfg_pin,
  input  wire gfm_func_t             cfg_func,
  // level write command
  input  wire logic                  lvl_wr,
  input  wire logic [2:0]            lvl_pin,
  input  wire logic                  lvl_val,
  // positioning mode and device events
  input  wire logic                  pos_mode,
  input  wire logic                  tx_burst,
  input  wire logic                  sync_pulse,
  input  wire logic [1:0]            net_state,
  // pad inputs
  input  wire logic [4:0]            mpin_in,
  // pad controls
  output gfm_pad_s                   pad,
  // host-visible state
  output logic [4:0]                 pin_level,
  output logic                       cfg_ack,
  output logic                       cfg_rej,
  output logic                       wake_req,
  output logic                       sim_present,
  output logic [19:0]                pin_func
);
  typedef struct packed {
    gfm_func_t [4:0] func;
    logic [4:0]      wlvl;
    gfm_pad_s        pad;
    logic [4:0]      lvl;
    logic            ack;
    logic            rej;
    logic            wake;
    logic            sim;
  } gfm_state_s;

  gfm_state_s st_r;
  gfm_state_s st_nxt;
  logic       ns_level;

  gfm_netstat u_ns (
    .clk       (clk),
    .reset     (reset),
    .net_state (net_state),
    .ns_level  (ns_level)
  );

  function automatic logic allowed(input logic [2:0] p, input gfm_func_t f);
    logic ok;
    ok = 1'b0;
    case (f)
      `GFM_F_OUTPUT, `GFM_F_INPUT, `GFM_F_NETSTAT, `GFM_F_POS_SUPPLY: ok = 1'b1;
      `GFM_F_DISABLED: ok = 1'b1;
      `GFM_F_TX_BURST: ok = (p == 3'h0);
      `GFM_F_DATA_RDY: ok = (p == 3'h2);
      `GFM_F_AID_SYNC: ok = (p == 3'h3);
      `GFM_F_SIM_DET:  ok = (p == 3'h4);
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction : allowed

  always_comb begin
    logic dup;
    logic spec;
    logic wk;
    logic sm;
    dup = 1'b0;
    wk  = 1'b0;
    sm  = 1'b0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.rej = 1'b0;
    spec = (cfg_func >= `GFM_F_POS_SUPPLY);
    for (int i = 0; i < 5; i++) begin
      if (spec && st_r.func[i] == cfg_func && i != int'(cfg_pin)) begin
        dup = 1'b1;
      end
    end
    if (cfg_wr) begin
      if (cfg_pin < 3'h5 && allowed(cfg_pin, cfg_func) && !dup) begin
        st_nxt.func[cfg_pin] = cfg_func;
        st_nxt.ack = 1'b1;
      end else begin
        st_nxt.rej = 1'b1;
      end
    end
    if (lvl_wr && lvl_pin < 3'h5) begin
      st_nxt.wlvl[lvl_pin] = lvl_val;
    end
    for (int i = 0; i < 5; i++) begin
      st_nxt.pad.out[i] = 1'b0;
      st_nxt.pad.oe[i]  = 1'b0;
      st_nxt.pad.pd[i]  = 1'b1;
      case (st_r.func[i])
        `GFM_F_OUTPUT: begin
          st_nxt.pad.out[i] = st_r.wlvl[i];
          st_nxt.pad.oe[i]  = 1'b1;
          st_nxt.pad.pd[i]  = 1'b0;
        end
        `GFM_F_INPUT: begin
          st_nxt.pad.pd[i] = 1'b0;
        end
        `GFM_F_NETSTAT: begin
          st_nxt.pad.out[i] = ns_level;
          st_nxt.pad.oe[i]  = 1'b1;
          st_nxt.pad.pd[i]  = 1'b0;
        end
        `GFM_F_TX_BURST: begin
          st_nxt.pad.out[i] = tx_burst;
          st_nxt.pad.oe[i]  = 1'b1;
          st_nxt.pad.pd[i]  = 1'b0;
        end
        `GFM_F_POS_SUPPLY: begin
          st_nxt.pad.out[i] = pos_mode;
          st_nxt.pad.oe[i]  = pos_mode;
          st_nxt.pad.pd[i]  = ~pos_mode;
        end
        `GFM_F_DATA_RDY: begin
          st_nxt.pad.pd[i] = ~pos_mode;
          wk = wk | (pos_mode & mpin_in[i]);
        end
        `GFM_F_AID_SYNC: begin
          st_nxt.pad.out[i] = pos_mode & sync_pulse;
          st_nxt.pad.oe[i]  = pos_mode;
          st_nxt.pad.pd[i]  = ~pos_mode;
        end
        `GFM_F_SIM_DET: begin
          st_nxt.pad.pd[i] = 1'b0;
          sm = mpin_in[i];
        end
        default: begin
        end
      endcase
    end
    st_nxt.lvl  = mpin_in;
    st_nxt.wake = wk;
    st_nxt.sim  = sm;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r      <= '0;
      st_r.func <= {`GFM_PIN5_RST, `GFM_PIN4_RST, `GFM_PIN3_RST,
                    `GFM_PIN2_RST, `GFM_PIN1_RST};
      st_r.pad.pd <= 5'h1F;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad         = st_r.pad;
  assign pin_level   = st_r.lvl;
  assign cfg_ack     = st_r.ack;
  assign cfg_rej     = st_r.rej;
  assign wake_req    = st_r.wake;
  assign sim_present = st_r.sim;
  assign pin_func    = st_r.func;

  burst_follow_a: assert property (@(posedge clk) disable iff (reset)
    st_r.func[0] == `GFM_F_TX_BURST |=> pad.out[0] == $past(tx_burst))
    else $error("burst pin does not follow burst");
  supply_drive_a: assert property (@(posedge clk) disable iff (reset)
    (pin_func[7:4] == `GFM_F_POS_SUPPLY && $stable(pin_func)) |=>
      (pad.oe[1] == $past(pos_mode) && pad.pd[1] != $past(pos_mode)))
    else $error("supply pin drive wrong");
  reject_bad_a: assert property (@(posedge clk) disable iff (reset)
    (cfg_wr && cfg_pin == 3'h1 && cfg_func == `GFM_F_TX_BURST) |=> cfg_rej && $stable(pin_func))
    else $error("illegal selection accepted");
  cfg_apply_a: assert property (@(posedge clk) disable iff (reset)
    cfg_ack |-> pin_func[$past(cfg_pin)*4 +: 4] == $past(cfg_func))
    else $error("accepted config not applied");
  disabled_pad_a: assert property (@(posedge clk) disable iff (reset)
    (pin_func[3:0] == `GFM_F_DISABLED)[*2] |-> !pad.oe[0] && pad.pd[0])
    else $error("disabled pin not floating with pull-down");
  output_lvl_a: assert property (@(posedge clk) disable iff (reset)
    (pin_func[7:4] == `GFM_F_OUTPUT && lvl_wr && lvl_pin == 3'h1 && !cfg_wr &&
      $stable(pin_func)) |=> ##1 pad.out[1] == $past(lvl_val, 2))
    else $error("output level not driven");
  input_read_a: assert property (@(posedge clk) disable iff (reset)
    ##1 pin_level == $past(mpin_in))
    else $error("pin level not sampled");
  wake_gate_a: assert property (@(posedge clk) disable iff (reset)
    !$past(pos_mode) |-> !wake_req)
    else $error("wake without positioning mode");
  sync_drive_a: assert property (@(posedge clk) disable iff (reset)
    pin_func[15:12] == `GFM_F_AID_SYNC |=> pad.oe[3] == $past(pos_mode) &&
      pad.out[3] == ($past(pos_mode) && $past(sync_pulse)) && pad.pd[3] != $past(pos_mode))
    else $error("sync pin drive wrong");
  netstat_out_a: assert property (@(posedge clk) disable iff (reset)
    pin_func[3:0] == `GFM_F_NETSTAT |=> pad.oe[0] && pad.out[0] == $past(ns_level))
    else $error("network status pin wrong");
  wake_on_a: assert property (@(posedge clk) disable iff (reset)
    (pin_func[11:8] == `GFM_F_DATA_RDY && pos_mode && mpin_in[2]) |=> wake_req)
    else $error("data ready did not wake");
  sim_follow_a: assert property (@(posedge clk) disable iff (reset)
    pin_func[19:16] == `GFM_F_SIM_DET |=> sim_present == $past(mpin_in[4]))
    else $error("card presence not followed");
endmodule : gfm_mux

// >>> tb/gfm_far_end.sv
`timescale 1ns/1ps
module gfm_far_end
  import gfm_pkg::*;
(
  // clock
  input  wire logic       clk,
  // pad controls from the block
  input  wire gfm_pad_s   pad,
  // far-side drivers
  input  wire logic [4:0] ext_en,
  input  wire logic [4:0] ext_val,
  // resolved pad levels
  output logic [4:0]      mpin_in
);
  logic [4:0] last_r;
  always_ff @(posedge clk) begin
    last_r <= mpin_in;
  end
  // an undriven pad with no pull wanders, so nothing may rely on it
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pad.oe[i]) begin
        mpin_in[i] = pad.out[i];
      end else if (ext_en[i]) begin
        mpin_in[i] = ext_val[i];
      end else if (pad.pd[i]) begin
        mpin_in[i] = 1'b0;
      end else begin
        mpin_in[i] = ~last_r[i];
      end
    end
  end
endmodule : gfm_far_end

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define GFM_CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top
  import gfm_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, lvl_wr = 1'b0, lvl_val = 1'b0;
  logic [2:0]  cfg_pin = 3'h0, lvl_pin = 3'h0;
  gfm_func_t   cfg_func = 4'h0;
  logic        pos_mode = 1'b0, tx_burst = 1'b0, sync_pulse = 1'b0;
  logic [1:0]  net_state = 2'h0;
  logic [4:0]  ext_en = 5'h10, ext_val = 5'h00, mpin_in, pin_level;
  gfm_pad_s    pad;
  logic        cfg_ack, cfg_rej, wake_req, sim_present;
  logic [19:0] pin_func;
  int          err_count = 0, samples_checked = 0, cycles = 0;

  always #2 clk = ~clk;

  gfm_mux u_gfm_mux (.clk(clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_pin(cfg_pin),
    .cfg_func(cfg_func), .lvl_wr(lvl_wr), .lvl_pin(lvl_pin), .lvl_val(lvl_val),
    .pos_mode(pos_mode), .tx_burst(tx_burst), .sync_pulse(sync_pulse), .net_state(net_state),
    .mpin_in(mpin_in), .pad(pad), .pin_level(pin_level), .cfg_ack(cfg_ack), .cfg_rej(cfg_rej),
    .wake_req(wake_req), .sim_present(sim_present), .pin_func(pin_func));
  gfm_far_end u_gfm_far_end (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .mpin_in(mpin_in));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic cfg(input logic [2:0] p, input gfm_func_t f, input logic ok);
    @(posedge clk);
    cfg_wr   <= 1'b1;
    cfg_pin  <= p;
    cfg_func <= f;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
    `GFM_CHK("cfg_ack", ok, cfg_ack)
    `GFM_CHK("cfg_rej", ~ok, cfg_rej)
  endtask : cfg

  task automatic lvl(input logic [2:0] p, input logic v);
    @(posedge clk);
    lvl_wr  <= 1'b1;
    lvl_pin <= p;
    lvl_val <= v;
    @(posedge clk);
    lvl_wr <= 1'b0;
    tick(3);
    `GFM_CHK("out_pad", {1'b1, v}, {pad.oe[p], pad.out[p]})
    `GFM_CHK("out_level", v, pin_level[p])
  endtask : lvl

  task automatic t_reset();
    tick(2);
    `GFM_CHK("func_rst", 20'h87640, pin_func)
    `GFM_CHK("pd_rst", 5'h1F, pad.pd)
    `GFM_CHK("oe_rst", 5'h00, pad.oe)
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    tick(3);
    `GFM_CHK("func_dflt", 20'h87640, pin_func)
    `GFM_CHK("oe_dflt", 5'h00, pad.oe)
    `GFM_CHK("pd_dflt", 5'h0F, pad.pd)
    $display("test reset done");
  endtask : t_reset

  task automatic t_pos();
    @(posedge clk);
    pos_mode   <= 1'b1;
    sync_pulse <= 1'b1;
    ext_en     <= 5'h14;
    ext_val    <= 5'h14;
    tick(4);
    `GFM_CHK("supply", 2'h3, {pad.oe[1], pad.out[1]})
    `GFM_CHK("sync", 2'h3, {pad.oe[3], pad.out[3]})
    `GFM_CHK("rdy_oe", 1'b0, pad.oe[2])
    `GFM_CHK("wake", 1'b1, wake_req)
    `GFM_CHK("sim", 1'b1, sim_present)
    @(posedge clk);
    sync_pulse <= 1'b0;
    ext_val    <= 5'h00;
    tick(4);
    `GFM_CHK("sync", 1'b0, pad.out[3])
    `GFM_CHK("wake", 1'b0, wake_req)
    `GFM_CHK("sim", 1'b0, sim_present)
    @(posedge clk);
    pos_mode <= 1'b0;
    ext_val  <= 5'h04;
    tick(4);
    `GFM_CHK("wake_off", 1'b0, wake_req)
    `GFM_CHK("rdy_pd", 1'b1, pad.pd[2])
    `GFM_CHK("supply_off", 2'h1, {pad.oe[1], pad.pd[1]})
    `GFM_CHK("sync_off", 2'h1, {pad.oe[3], pad.pd[3]})
    @(posedge clk);
    pos_mode <= 1'b1;
    tick(4);
    `GFM_CHK("wake_on", 1'b1, wake_req)
    $display("test positioning done");
  endtask : t_pos

  task automatic t_cfg();
    cfg(3'h5, 4'h2, 1'b0);
    cfg(3'h1, 4'h5, 1'b0);
    cfg(3'h0, 4'h8, 1'b0);
    cfg(3'h2, 4'h7, 1'b0);
    cfg(3'h3, 4'h6, 1'b0);
    cfg(3'h4, 4'h5, 1'b0);
    cfg(3'h0, 4'h9, 1'b0);
    cfg(3'h0, 4'h4, 1'b0);
    cfg(3'h1, 4'h0, 1'b1);
    `GFM_CHK("func", 20'h87600, pin_func)
    cfg(3'h0, 4'h4, 1'b1);
    tick(1);
    `GFM_CHK("oe", 5'h09, pad.oe)
    `GFM_CHK("supply0", 1'b1, pad.out[0])
    `GFM_CHK("dis_pd", 1'b1, pad.pd[1])
    cfg(3'h2, 4'h4, 1'b0);
    cfg(3'h0, 4'h5, 1'b1);
    @(posedge clk);
    tx_burst <= 1'b1;
    ext_en   <= 5'h10;
    tick(3);
    `GFM_CHK("burst", 2'h3, {pad.oe[0], pad.out[0]})
    @(posedge clk);
    tx_burst <= 1'b0;
    tick(3);
    `GFM_CHK("burst", 1'b0, pad.out[0])
    cfg(3'h2, 4'h4, 1'b1);
    tick(1);
    `GFM_CHK("supply2", 2'h3, {pad.oe[2], pad.out[2]})
    $display("test config done");
  endtask : t_cfg

  task automatic t_gpio();
    cfg(3'h1, 4'h1, 1'b1);
    lvl(3'h1, 1'b1);
    lvl(3'h1, 1'b0);
    cfg(3'h1, 4'h2, 1'b1);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      ext_en  <= 5'h12;
      ext_val <= {3'h0, v[0], 1'b0};
      tick(3);
      `GFM_CHK("in_oe", 1'b0, pad.oe[1])
      `GFM_CHK("in_level", v[0], pin_level[1])
    end
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_ns();
    @(posedge clk);
    net_state <= 2'h2;
    for (int i = 0; i < 5; i++) begin
      cfg(i[2:0], 4'h3, 1'b1);
    end
    tick(3);
    `GFM_CHK("ns_oe", 5'h1F, pad.oe)
    `GFM_CHK("ns_on", 5'h1F, pad.out)
    for (int i = 0; i < 5; i++) begin
      cfg(i[2:0], 4'h0, 1'b1);
    end
    tick(2);
    `GFM_CHK("dis_oe", 5'h00, pad.oe)
    `GFM_CHK("dis_pd", 5'h1F, pad.pd)
    $display("test netstat done");
  endtask : t_ns

  initial begin
    t_reset();
    t_pos();
    t_cfg();
    t_gpio();
    t_ns();
    end_sim();
  end
endmodule : tb_top
